// ===== verilog/fpm_top.v
// flash sector protection, reset-to-read control and memory select routing
// Functional notes
// RULE1: protection bits readable by the mcu, never changed by mcu writes
// RULE2: program or erase aimed at a protected sector is silently dropped
// RULE3: verify of a protected sector reads the stored data like a read
// RULE4: primary protect register bit i shows sector i protection
// RULE5: secondary register bits 0-3 sector protect, 4-6 zero, 7 security
// RULE6: reset instruction is one write, optionally after the two unlock writes
// RULE7: mcu issues reset after status or id reads and after errors
// RULE8: after an error, reset instruction returns to read within 25 us
// RULE9: reset instruction ignored during byte program or bulk erase
// RULE10: reset instruction aborts sector erase, read mode within 25 us
// RULE11: reset pin aborts any cycle; return may take 25 us if busy
// RULE12: system should hold non power-on reset pulses at least 25 us
// RULE13: sram enabled only while sram select is high
// RULE14: secondary sector wins over an overlapping primary sector
// RULE15: sram, io and peripheral io win over any flash sector
// RULE16: selects of the same priority level must not overlap
// RULE17: fetch strobe means program space, read strobe means data space
// RULE18: map bits gate each space, bit 7 enables peripheral io mode
// RULE19: map register loads a boot value and is writable at run time
// RULE20: separate spaces need map value 0ch
// RULE21: primary flash in both spaces needs map bits 2 and 4
// RULE22: error flag reads one after a failed program or erase
// RULE23: writes to protect registers leave protection bits unchanged
`timescale 1ns/1ps
`include "fpm_defs.vh"
module fpm_top #(
    parameter [7:0] MAP_INIT = `FPM_MAP_INIT,
    parameter [7:0] RESET_CODE = `FPM_RESET_CODE
) (
    input wire sys_clk,
    input wire resetn,
    input wire [11:0] mcu_addr,
    input wire [7:0] mcu_wdata,
    input wire mcu_wr_n,
    input wire control_input_1_n,
    input wire control_input_2_n,
    input wire mcu_reset_n,
    input wire config_register_block_select,
    input wire [7:0] primary_sector_selects,
    input wire [3:0] secondary_sector_selects,
    input wire sram_select,
    input wire io_select,
    input wire pio_select,
    input wire [7:0] prim_prot_bits,
    input wire [3:0] sec_prot_bits,
    input wire security_bit,
    input wire op_start,
    input wire [1:0] op_kind,
    input wire array_done,
    input wire array_fail,
    output reg [7:0] mcu_rdata_q,
    output reg mcu_rdata_valid_q,
    output wire [7:0] primary_sector_enable,
    output wire [3:0] secondary_sector_enable,
    output wire sram_enable,
    output wire io_enable,
    output wire pio_enable,
    output wire op_grant,
    output reg flash_abort_q,
    output wire flash_read_mode,
    output wire flash_busy,
    output wire error_flag_bit,
    output wire [7:0] memory_space_map
);
    localparam CNT_W = 12;
    localparam RECOVER_ALL = `FPM_RECOVER_US * `FPM_CLK_MHZ; // 3125 cycles, fits 12 bits
    localparam [CNT_W-1:0] RECOVER_CYC = RECOVER_ALL[CNT_W-1:0];
    localparam [2:0] ST_READ = 3'h0;
    localparam [2:0] ST_PROG = 3'h1;
    localparam [2:0] ST_BULK = 3'h2;
    localparam [2:0] ST_SECT = 3'h3;
    localparam [2:0] ST_ERR = 3'h4;
    localparam [2:0] ST_RECOV = 3'h5;
    localparam [1:0] UL_IDLE = 2'h0;
    localparam [1:0] UL_ONE = 2'h1;
    localparam [1:0] UL_TWO = 2'h2;

    wire [3:0] pins_lvl;
    wire wr_n_s;
    wire rd_n_s;
    wire program_fetch_strobe_n_s;
    wire rst_n_s;
    reg wr_n_prev_q;
    reg rst_n_prev_q;
    reg [7:0] map_q;
    reg [7:0] map_d;
    reg [7:0] prim_prot_q;
    reg [3:0] sec_prot_q;
    reg security_q;
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [CNT_W-1:0] cnt_q;
    reg [CNT_W-1:0] cnt_d;
    reg err_q;
    reg err_d;
    reg abort_d;
    reg [1:0] unlock_q;
    reg [1:0] unlock_d;
    wire wr_evt;
    wire rst_pulse;
    wire reset_instr;
    wire any_flash_sel;
    wire rd_act;
    wire program_fetch_strobe_act;
    wire hi_level;
    wire sec_hit;
    wire target_protected;

    // function reused for both protection checks
    function sel_protected;
        input [7:0] sel;
        input [7:0] prot;
        begin
            sel_protected = |(sel & prot);
        end
    endfunction

    // strobes and the reset pin arrive from the mcu side
    fpm_pin_sync #(
        .WIDTH(4),
        .IDLE(4'hf)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .pin_in({mcu_reset_n, control_input_2_n, control_input_1_n, mcu_wr_n}),
        .level_q(pins_lvl)
    );
    assign wr_n_s = pins_lvl[0];
    assign rd_n_s = pins_lvl[1];
    assign program_fetch_strobe_n_s = pins_lvl[2];
    assign rst_n_s = pins_lvl[3];

    assign wr_evt = wr_n_prev_q & ~wr_n_s;
    // reset pin acts on its rising edge, once the pulse is over
    assign rst_pulse = ~rst_n_prev_q & rst_n_s;

    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_n_prev_q <= 1'b1;
            rst_n_prev_q <= 1'b1;
        end
        else
        begin
            wr_n_prev_q <= wr_n_s;
            rst_n_prev_q <= rst_n_s;
        end
    end

    // protection image follows the jtag or programmer side only
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            prim_prot_q <= 8'h00;
            sec_prot_q <= 4'h0;
            security_q <= 1'b0;
        end
        else
        begin
            prim_prot_q <= prim_prot_bits; // see RULE1
            sec_prot_q <= sec_prot_bits; // see RULE23
            security_q <= security_bit;
        end
    end

    // memory space map, boot value then mcu writable
    always @*
    begin
        map_d = map_q;
        if (wr_evt && config_register_block_select
            && mcu_addr[`FPM_OFS_W-1:0] == `FPM_OFS_MAP)
            map_d = mcu_wdata & `FPM_MAP_USED; // see RULE19
    end

    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            map_q <= MAP_INIT & `FPM_MAP_USED; // see RULE19
        else
            map_q <= map_d;
    end
    assign memory_space_map = map_q;

    // register reads; protect registers ignore writes entirely
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mcu_rdata_q <= 8'h00;
            mcu_rdata_valid_q <= 1'b0;
        end
        else
        begin
            mcu_rdata_valid_q <= 1'b0;
            if (!rd_n_s && config_register_block_select)
            begin
                mcu_rdata_valid_q <= 1'b1;
                case (mcu_addr[`FPM_OFS_W-1:0])
                    `FPM_OFS_PRIM_PROT: mcu_rdata_q <= prim_prot_q; // see RULE4
                    `FPM_OFS_SEC_PROT: mcu_rdata_q <= {security_q, 3'h0, sec_prot_q}; // see RULE5
                    `FPM_OFS_MAP: mcu_rdata_q <= map_q;
                    default: mcu_rdata_q <= 8'h00;
                endcase
            end
            else if (!rd_n_s && any_flash_sel && (state_q != ST_READ))
            begin
                // status read while busy or failed carries the error flag
                mcu_rdata_valid_q <= 1'b1;
                mcu_rdata_q <= {2'h0, err_q, 5'h00}; // see RULE22
            end
        end
    end

    // space gating and priority levels
    assign rd_act = ~rd_n_s; // see RULE17
    assign program_fetch_strobe_act = ~program_fetch_strobe_n_s; // see RULE17
    assign pio_enable = pio_select & map_q[`FPM_MAP_PIO]; // see RULE18
    assign sram_enable = sram_select & (rd_act | ~wr_n_s
        | (program_fetch_strobe_act & map_q[`FPM_MAP_SRAM_CODE])); // see RULE13
    assign io_enable = io_select & ~program_fetch_strobe_act;
    assign hi_level = sram_select | io_select | pio_enable; // see RULE15
    assign sec_hit = |secondary_sector_selects;
    assign secondary_sector_enable = (hi_level ? 4'h0 : secondary_sector_selects)
        & {4{(rd_act & map_q[`FPM_MAP_SEC_DATA]) | (program_fetch_strobe_act & map_q[`FPM_MAP_SEC_CODE])
        | ~wr_n_s}}; // see RULE18
    assign primary_sector_enable = ((hi_level | sec_hit) ? 8'h00 : primary_sector_selects)
        & {8{(rd_act & map_q[`FPM_MAP_PRIM_DATA]) | (program_fetch_strobe_act & map_q[`FPM_MAP_PRIM_CODE])
        | ~wr_n_s}}; // see RULE14
    assign any_flash_sel = ~hi_level & (sec_hit | (|primary_sector_selects));

    // protection of the sector the current address routes to
    assign target_protected = sec_hit
        ? sel_protected({4'h0, secondary_sector_selects}, {4'h0, sec_prot_q})
        : sel_protected(primary_sector_selects, prim_prot_q);
    // reads, including verify, are never blocked by protection
    assign op_grant = op_start & (state_q == ST_READ) & ~hi_level
        & ~target_protected; // see RULE2
    // see RULE3: verify of a protected sector follows the normal read path above

    // unlock tracking, optional ahead of the reset code
    always @*
    begin
        unlock_d = UL_IDLE;
        if (wr_evt && any_flash_sel)
        begin
            if (mcu_addr == `FPM_UNLOCK1_ADDR && mcu_wdata == `FPM_UNLOCK1_DATA)
                unlock_d = UL_ONE;
            else if (unlock_q == UL_ONE && mcu_addr == `FPM_UNLOCK2_ADDR
                && mcu_wdata == `FPM_UNLOCK2_DATA)
                unlock_d = UL_TWO;
        end
        else if (!wr_evt)
            unlock_d = unlock_q;
    end
    // a single write of the code counts, unlocked or not
    assign reset_instr = wr_evt && any_flash_sel && mcu_wdata == RESET_CODE; // see RULE6

    // flash operation state
    always @*
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        err_d = err_q;
        abort_d = 1'b0;
        case (state_q)
            ST_READ:
            begin
                if (op_grant)
                begin
                    case (op_kind)
                        `FPM_OP_PROGRAM: state_d = ST_PROG;
                        `FPM_OP_BULK: state_d = ST_BULK;
                        default: state_d = ST_SECT;
                    endcase
                end
            end
            ST_PROG, ST_BULK:
            begin
                // a reset instruction here is dropped on purpose
                if (rst_pulse)
                begin
                    abort_d = 1'b1; // see RULE11
                    state_d = ST_RECOV;
                    cnt_d = RECOVER_CYC;
                end
                else if (array_done)
                begin
                    err_d = array_fail; // see RULE22
                    state_d = array_fail ? ST_ERR : ST_READ;
                end
                else if (reset_instr)
                    state_d = state_q; // see RULE9
            end
            ST_SECT:
            begin
                if (rst_pulse || reset_instr)
                begin
                    abort_d = 1'b1; // see RULE10
                    state_d = ST_RECOV;
                    cnt_d = RECOVER_CYC;
                end
                else if (array_done)
                begin
                    err_d = array_fail; // see RULE22
                    state_d = array_fail ? ST_ERR : ST_READ;
                end
            end
            ST_ERR:
            begin
                if (rst_pulse)
                begin
                    err_d = 1'b0; // see RULE11
                    state_d = ST_READ;
                end
                else if (reset_instr)
                begin
                    state_d = ST_RECOV; // see RULE8
                    cnt_d = RECOVER_CYC;
                end
            end
            ST_RECOV:
            begin
                // bounded wait keeps the return inside the allowed time
                if (cnt_q <= 12'h001)
                begin
                    cnt_d = 12'h000;
                    err_d = 1'b0;
                    state_d = ST_READ; // see RULE8
                end
                else
                    cnt_d = cnt_q - 12'h001;
            end
            default:
            begin
                state_d = ST_READ;
                cnt_d = 12'h000;
            end
        endcase
    end

    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= ST_READ;
            cnt_q <= 12'h000;
            err_q <= 1'b0;
            flash_abort_q <= 1'b0;
            unlock_q <= UL_IDLE;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            err_q <= err_d;
            flash_abort_q <= abort_d;
            unlock_q <= unlock_d;
        end
    end

    assign flash_read_mode = (state_q == ST_READ);
    assign flash_busy = (state_q == ST_PROG) | (state_q == ST_BULK) | (state_q == ST_SECT);
    assign error_flag_bit = err_q;
endmodule // fpm_top

// ===== verilog/fpm_defs.vh
// constants for the flash protect and memory select block
`ifndef FPM_DEFS_VH
`define FPM_DEFS_VH
// config block register offsets (low address bits inside the config block)
`define FPM_OFS_W 8
`define FPM_OFS_PRIM_PROT 8'hc0
`define FPM_OFS_SEC_PROT 8'hc2
`define FPM_OFS_MAP 8'hb2
// memory_space_map field positions
`define FPM_MAP_PIO 7
`define FPM_MAP_PRIM_DATA 4
`define FPM_MAP_SEC_DATA 3
`define FPM_MAP_PRIM_CODE 2
`define FPM_MAP_SEC_CODE 1
`define FPM_MAP_SRAM_CODE 0
`define FPM_MAP_USED 8'h9f
`define FPM_MAP_INIT 8'h00
// secondary protect register layout
`define FPM_SEC_SECURITY 7
// unlock cycles
`define FPM_UNLOCK1_ADDR 12'h555
`define FPM_UNLOCK1_DATA 8'haa
`define FPM_UNLOCK2_ADDR 12'haaa
`define FPM_UNLOCK2_DATA 8'h55
// flash reset instruction code, value is arbitrary
`define FPM_RESET_CODE 8'hf0
// data bit carrying the error flag in status reads
`define FPM_ERR_BIT 5
// timing
`define FPM_CLK_MHZ 125
`define FPM_RECOVER_US 25
// operation kinds
`define FPM_OP_PROGRAM 2'h0
`define FPM_OP_BULK 2'h1
`define FPM_OP_SECTOR 2'h2
`endif

// ===== verilog/fpm_pin_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module fpm_pin_sync #(
    parameter WIDTH = 4,
    parameter [WIDTH-1:0] IDLE = {WIDTH{1'b1}}
) (
    input wire sys_clk,
    input wire resetn,
    input wire [WIDTH-1:0] pin_in,
    output reg [WIDTH-1:0] level_q
);
    reg [WIDTH-1:0] s1_q;
    reg [WIDTH-1:0] s2_q;
    reg [WIDTH-1:0] s3_q;
    integer i;
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s1_q <= IDLE;
            s2_q <= IDLE;
            s3_q <= IDLE;
            level_q <= IDLE;
        end
        else
        begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // a change counts only once stages two and three agree
            for (i = 0; i < WIDTH; i = i + 1)
            begin
                if (s2_q[i] == s3_q[i])
                    level_q[i] <= s3_q[i];
            end
        end
    end
endmodule // fpm_pin_sync

// ===== testbench/fpm_top_asserts.sv
// assertion checker for the protect and memory select block
`timescale 1ns/1ps
module fpm_top_asserts (
    input wire sys_clk,
    input wire resetn,
    input wire [7:0] primary_sector_selects,
    input wire [3:0] secondary_sector_selects,
    input wire sram_select,
    input wire io_select,
    input wire pio_select,
    input wire [7:0] prim_prot_bits,
    input wire array_done,
    input wire array_fail,
    input wire [7:0] primary_sector_enable,
    input wire [3:0] secondary_sector_enable,
    input wire sram_enable,
    input wire io_enable,
    input wire pio_enable,
    input wire op_grant,
    input wire flash_abort_q,
    input wire flash_read_mode,
    input wire flash_busy,
    input wire error_flag_bit,
    input wire [7:0] memory_space_map
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // cycles since an abort, cleared once read mode is back
    logic [12:0] rec_q;
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            rec_q <= 13'h0;
        else if (flash_read_mode)
            rec_q <= 13'h0;
        else if (flash_abort_q || rec_q != 13'h0)
            rec_q <= rec_q + 13'h1;
    end
    a_sram_gated: assert property (sram_enable |-> sram_select)
        else $error("sram enabled without its select");
    a_secondary_wins: assert property (|secondary_sector_enable |-> !primary_sector_enable)
        else $error("primary sector enabled beside a secondary one");
    a_high_prio_wins: assert property ((sram_enable || io_enable || pio_enable)
        |-> !primary_sector_enable && !secondary_sector_enable)
        else $error("flash sector enabled beside sram or io");
    a_grant_unprot: assert property (op_grant && $stable(prim_prot_bits) && !secondary_sector_selects
        |-> (primary_sector_selects & prim_prot_bits) == 8'h00)
        else $error("operation granted on a protected sector");
    a_grant_blocked: assert property (op_grant |-> !(sram_select || io_select || pio_select))
        else $error("operation granted under a high priority select");
    a_grant_busy: assert property (op_grant |=> flash_busy)
        else $error("granted operation did not start");
    a_fail_flag: assert property (flash_busy && array_done && array_fail |=> error_flag_bit)
        else $error("failed operation left error flag clear");
    a_pass_clean: assert property (flash_busy && array_done && !array_fail
        |=> flash_read_mode && !error_flag_bit)
        else $error("good operation did not return to read mode");
    a_abort_once: assert property (flash_abort_q |=> !flash_abort_q)
        else $error("abort pulse longer than one cycle");
    a_recover_bound: assert property (rec_q <= 13'hc36)
        else $error("read mode not back within recovery time");
    a_map_unused: assert property (memory_space_map[6:5] == 2'h0)
        else $error("unused map bits read nonzero");
    c_grant: cover property (op_grant);
    c_abort: cover property (flash_abort_q);
    c_error: cover property ($rose(error_flag_bit));
    c_overlap: cover property (|secondary_sector_enable && |primary_sector_selects);
endmodule // fpm_top_asserts
bind fpm_top fpm_top_asserts u_chk (.*);

// ===== testbench/fpm_array_model.sv
// flash array model: requests operations and reports their end
`timescale 1ns/1ps
module fpm_array_model (
    input wire sys_clk,
    input wire go,
    input wire [1:0] kind,
    input wire fail,
    input wire [15:0] delay,
    input wire op_grant,
    input wire flash_abort_q,
    output logic op_start,
    output logic [1:0] op_kind,
    output logic array_done,
    output logic array_fail
);
    int cnt = 0;
    initial {op_start, op_kind, array_done, array_fail} = 5'h0;
    always @(posedge sys_clk)
    begin
        op_start <= #1 go;
        // no stale kind or fail value outside their strobes
        op_kind <= #1 go ? kind : ~op_kind;
        array_done <= #1 (cnt == 1);
        array_fail <= #1 (cnt == 1) ? fail : ~array_fail;
        if (op_start && op_grant)
            cnt <= delay;
        else if (flash_abort_q)
            cnt <= 0;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
endmodule // fpm_array_model

// ===== testbench/fpm_top_tb.sv
// self-checking bench for the protect and memory select block
`timescale 1ns/1ps
`include "fpm_defs.vh"
module fpm_top_tb;
    logic sys_clk = 0, resetn = 0, mcu_wr_n = 1, control_input_1_n = 1, control_input_2_n = 1;
    logic mcu_reset_n = 1, config_register_block_select = 0, sram_select = 0, io_select = 0;
    logic pio_select = 0, security_bit = 0, go = 0, fail = 0, seen = 0, abort_seen = 0;
    logic [11:0] mcu_addr = 0;
    logic [7:0] mcu_wdata = 0, primary_sector_selects = 0, prim_prot_bits = 0, pp, mv[4];
    logic [3:0] secondary_sector_selects = 0, sec_prot_bits = 0, sp;
    logic [1:0] kind = 0;
    logic [15:0] delay = 0;
    wire [7:0] mcu_rdata_q, primary_sector_enable, memory_space_map;
    wire [3:0] secondary_sector_enable;
    wire [1:0] op_kind;
    wire mcu_rdata_valid_q, sram_enable, io_enable, pio_enable, op_grant, flash_abort_q;
    wire flash_read_mode, flash_busy, error_flag_bit, op_start, array_done, array_fail;
    logic [7:0] exp_q[$];
    int bad_count = 0, total_checks = 0;
    fpm_top u_dut (.*);
    fpm_array_model u_arr (.*);
    always #4 sys_clk = ~sys_clk;
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // strobes held 5 cycles so the pin synchroniser always sees them
    task automatic wr(input [11:0] a, input [7:0] d, input logic cfg);
        config_register_block_select = cfg;
        mcu_addr = a;
        mcu_wdata = d;
        mcu_wr_n = 0;
        tick(5);
        mcu_wr_n = 1;
        tick(4);
        config_register_block_select = 0;
        tick(1);
    endtask
    task automatic rd(input [7:0] a, input [7:0] e);
        exp_q.push_back(e);
        config_register_block_select = 1;
        mcu_addr = {4'h0, a};
        control_input_1_n = 0;
        tick(5);
        control_input_1_n = 1;
        tick(4);
        config_register_block_select = 0;
        tick(1);
    endtask
    task automatic route(input [7:0] m, input logic f, input [13:0] s, input [13:0] e);
        wr(12'h0b2, m, 1);
        {primary_sector_selects, secondary_sector_selects, sram_select, io_select} = s;
        control_input_1_n = f;
        control_input_2_n = !f;
        tick(5);
        chk("route", {2'h0, primary_sector_enable, secondary_sector_enable, sram_enable,
            io_enable}, {2'h0, e});
        {control_input_1_n, control_input_2_n} = 2'h3;
        tick(5);
        {primary_sector_selects, secondary_sector_selects, sram_select, io_select} = 14'h0;
    endtask
    task automatic op(input [1:0] k, input logic f, input [15:0] d);
        kind = k;
        fail = f;
        delay = d;
        go = 1;
        tick(1);
        go = 0;
        tick(2);
    endtask
    task automatic wait_read(input int lim);
        for (int i = 0; i < lim && flash_read_mode !== 1'b1; i++)
            tick(1);
        chk("read_mode", {7'h0, flash_read_mode}, 8'h01);
    endtask
    always @(posedge sys_clk)
    begin
        if (mcu_rdata_valid_q === 1'b1 && !seen)
        begin
            if (exp_q.size() == 0)
                chk("rdata_extra", 16'h0, 16'h1);
            else
                chk("rdata", mcu_rdata_q, exp_q.pop_front());
        end
        seen <= (mcu_rdata_valid_q === 1'b1);
        if (flash_abort_q === 1'b1)
            abort_seen <= 1;
    end
    initial
    begin
        #240000;
        bad_count++;
        complete_run;
    end
    initial
    begin
        void'($urandom(89));
        pp = $urandom;
        sp = $urandom;
        {prim_prot_bits, sec_prot_bits, security_bit} = {pp, sp, pp[0]};
        tick(5);
        resetn = 1;
        tick(2);
        chk("map_reset", memory_space_map, 8'h00);
        rd(8'hb2, 8'h00);
        rd(8'hc0, pp);
        rd(8'hc2, {pp[0], 3'h0, sp});
        rd(8'h17, 8'h00);
        wr(12'h0c0, ~pp, 1);
        wr(12'h0c2, ~{4'h0, sp}, 1);
        rd(8'hc0, pp);
        rd(8'hc2, {pp[0], 3'h0, sp});
        mv = '{8'h0c, 8'h14, 8'hff, 8'h00};
        mv[3] = $urandom;
        foreach (mv[i])
        begin
            wr(12'h0b2, mv[i], 1);
            rd(8'hb2, mv[i] & 8'h9f);
        end
        resetn = 0;
        tick(5);
        resetn = 1;
        tick(2);
        chk("map_rearm", memory_space_map, 8'h00);
        // selects of one level never overlap in these cases
        route(8'h10, 0, 14'h0040, 14'h0040);
        route(8'h08, 0, 14'h0040, 14'h0000);
        route(8'h18, 0, 14'h0084, 14'h0004);
        route(8'h0c, 1, 14'h0100, 14'h0100);
        route(8'h0c, 0, 14'h0008, 14'h0008);
        route(8'h0c, 1, 14'h0008, 14'h0000);
        route(8'h14, 1, 14'h0200, 14'h0200);
        route(8'h14, 0, 14'h0200, 14'h0200);
        route(8'h1f, 0, 14'h0042, 14'h0002);
        route(8'h00, 1, 14'h0002, 14'h0000);
        route(8'h01, 1, 14'h0002, 14'h0002);
        route(8'h10, 0, 14'h0041, 14'h0001);
        wr(12'h0b2, 8'h80, 1);
        pio_select = 1;
        tick(1);
        chk("pio", {7'h0, pio_enable}, 16'h1);
        wr(12'h0b2, 8'h00, 1);
        chk("pio_off", {7'h0, pio_enable}, 16'h0);
        pio_select = 0;
        {prim_prot_bits, sec_prot_bits, primary_sector_selects} = {8'hfe, 4'h0, 8'h01};
        tick(2);
        op(`FPM_OP_PROGRAM, 0, 20);
        chk("busy", {7'h0, flash_busy}, 8'h01);
        wait_read(40);
        chk("err", {7'h0, error_flag_bit}, 8'h00);
        prim_prot_bits = 8'h01;
        tick(2);
        op(`FPM_OP_SECTOR, 0, 20);
        chk("busy", {7'h0, flash_busy}, 8'h00);
        prim_prot_bits = 8'hfe;
        tick(2);
        op(`FPM_OP_PROGRAM, 1, 20);
        tick(30);
        chk("err", {7'h0, error_flag_bit}, 8'h01);
        // status read on a flash sector while failed shows the error bit
        exp_q.push_back(8'h20);
        control_input_1_n = 0;
        tick(5);
        control_input_1_n = 1;
        tick(5);
        wr(`FPM_UNLOCK1_ADDR, `FPM_UNLOCK1_DATA, 0);
        wr(`FPM_UNLOCK2_ADDR, `FPM_UNLOCK2_DATA, 0);
        wr(12'h000, `FPM_RESET_CODE, 0);
        wait_read(3200);
        chk("err", {7'h0, error_flag_bit}, 8'h00);
        for (int k = 0; k < 2; k++)
        begin
            op(k[1:0], 0, 400);
            wr(12'h000, `FPM_RESET_CODE, 0);
            chk("busy", {7'h0, flash_busy}, 8'h01);
            wait_read(500);
        end
        abort_seen = 0;
        op(`FPM_OP_BULK, 0, 4000);
        mcu_reset_n = 0;
        tick(3200);
        mcu_reset_n = 1;
        wait_read(3300);
        chk("abort", {7'h0, abort_seen}, 8'h01);
        abort_seen = 0;
        op(`FPM_OP_SECTOR, 0, 4000);
        wr(12'h000, `FPM_RESET_CODE, 0);
        wait_read(3200);
        chk("abort", {6'h0, abort_seen, flash_busy}, 8'h02);
        complete_run;
    end
endmodule // fpm_top_tb
